// >>> shared/sim_boot_pkg.sv
// constants and carrier types for the simulation reply and boot loader block
// assumes a 50 MHz system clock and a byte-wide serial receiver and transmitter
package sim_boot_pkg;

  // timing
  localparam longint unsigned CLK_HZ = 50_000_000;
  localparam longint unsigned BOOT_WINDOW_MS = 3000;
  localparam longint unsigned LOAD_QUIET_MS = 3000;
  localparam longint unsigned PULSE_TIMEOUT_S = 300;
  localparam longint unsigned BOOT_WINDOW_CYC = CLK_HZ * BOOT_WINDOW_MS / 1000;
  localparam longint unsigned LOAD_QUIET_CYC = CLK_HZ * LOAD_QUIET_MS / 1000;
  localparam longint unsigned PULSE_TIMEOUT_CYC = CLK_HZ * PULSE_TIMEOUT_S;

  // arithmetic: period ms = counts * 1000 / 460800, temp tenths = raw * 3300 / 1024 - 500
  localparam logic [47:0] COUNT_RATE_HZ = 48'h0000_0007_0800;
  localparam logic [47:0] MS_PER_S = 48'h0000_0000_03E8;
  localparam logic [47:0] TEMP_MUL = 48'h0000_0000_0339;
  localparam logic [47:0] TEMP_ROUND = 48'h0000_0000_0080;
  localparam int TEMP_SHIFT = 8;
  localparam logic [47:0] TEMP_OFS_TENTHS = 48'h0000_0000_01F4;
  localparam logic [47:0] MAG_MAX = 48'h0000_0000_270F;
  localparam logic [47:0] DEC_BASE = 48'h0000_0000_000A;

  // reply columns
  localparam logic [6:0] COL_COUNT = 7'h02, COL_FREQ = 7'h0E, COL_RAW = 7'h1A;
  localparam logic [6:0] COL_RSEP = 7'h26, COL_MAG = 7'h28, COL_HZ = 7'h30;
  localparam logic [6:0] COL_CNT2 = 7'h3D, COL_PER = 7'h49, COL_TEMP = 7'h56;
  localparam logic [6:0] COL_CRLF = 7'h5D, REPLY_LEN = 7'h5F, ACK_LEN = 7'h04;

  // characters
  localparam logic [7:0] CH_S = 8'h53, CH_X = 8'h78, CH_COLON = 8'h3A, CH_RESET = 8'h19;
  localparam logic [7:0] CH_CR = 8'h0D, CH_LF = 8'h0A, CH_COMMA = 8'h2C, CH_ZERO = 8'h30;
  localparam logic [7:0] CH_SPACE = 8'h20, CH_MINUS = 8'h2D, CH_DOT = 8'h2E;
  localparam logic [7:0] CH_C = 8'h63, CH_F = 8'h66, CH_T = 8'h74, CH_R = 8'h72;
  localparam logic [7:0] CH_M = 8'h6D, CH_HU = 8'h48, CH_Z = 8'h7A, CH_SEC = 8'h73;
  localparam logic [7:0] CH_CU = 8'h43, CH_OU = 8'h4F, CH_K = 8'h6B;

  // program memory write carrier
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } prog_wr_t;

endpackage

// >>> rtl/udiv.sv
// sequential restoring unsigned divider, one quotient bit per clock
// assumes start_i is a one-cycle pulse given only while no division runs
`timescale 1ns/1ps
`default_nettype none
module udiv #(
  parameter int W = 48
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // request
  input wire logic start_i,
  input wire logic [W-1:0] num_i,
  input wire logic [W-1:0] den_i,
  // answer
  output logic done_o,
  output logic [W-1:0] quo_o,
  output logic [W-1:0] rem_o
);
  localparam int CW = $clog2(W + 1);

  if (W < 2)
  begin : g_chk
    $error("udiv width too small");
  end

  logic run_q, run_d, done_q, done_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [W-1:0] den_q, den_d, quo_q, quo_d, rem_q, rem_d;

  always_comb
  begin
    logic [W:0] trial;
    trial = '0;
    run_d = run_q;
    cnt_d = cnt_q;
    den_d = den_q;
    quo_d = quo_q;
    rem_d = rem_q;
    done_d = 1'b0;
    if (start_i)
    begin
      run_d = 1'b1;
      cnt_d = CW'(W);
      quo_d = num_i;
      rem_d = '0;
      den_d = den_i;
    end
    else if (run_q)
    begin
      trial = {rem_q, quo_q[W-1]} - {1'b0, den_q};
      if (!trial[W])
      begin
        rem_d = trial[W-1:0];
        quo_d = {quo_q[W-2:0], 1'b1};
      end
      else
      begin
        rem_d = {rem_q[W-2:0], quo_q[W-1]};
        quo_d = {quo_q[W-2:0], 1'b0};
      end
      cnt_d = cnt_q - 1'b1;
      if (cnt_q == CW'(1))
      begin
        run_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= '0;
      den_q <= '0;
      quo_q <= '0;
      rem_q <= '0;
    end
    else
    begin
      run_q <= run_d;
      done_q <= done_d;
      cnt_q <= cnt_d;
      den_q <= den_d;
      quo_q <= quo_d;
      rem_q <= rem_d;
    end
  end

  assign done_o = done_q;
  assign quo_o = quo_q;
  assign rem_o = rem_q;
endmodule
`default_nettype wire

// >>> rtl/sim_reply_and_boot_loader.sv
// simulation reply builder, boot loader and sensor period timeout
// assumes byte receiver and transmitter on clk_sys_i; program memory and cpu reset outside
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module sim_reply_and_boot_loader #(
  parameter longint unsigned BOOT_WINDOW_CYC = sim_boot_pkg::BOOT_WINDOW_CYC,
  parameter longint unsigned LOAD_QUIET_CYC = sim_boot_pkg::LOAD_QUIET_CYC,
  parameter longint unsigned PULSE_TIMEOUT_CYC = sim_boot_pkg::PULSE_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // received bytes
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // transmitted bytes
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  // calculated brightness, hundredths, signed
  input wire logic [15:0] sky_mag_i,
  // processor and program memory
  output logic cpu_reset_o,
  output sim_boot_pkg::prog_wr_t prog_wr_o,
  // light sensor
  input wire logic sensor_pulse_i,
  output logic [33:0] period_cycles_o,
  output logic period_valid_o,
  output logic pulse_timeout_o
);
  import sim_boot_pkg::*;

  if (BOOT_WINDOW_CYC < 2 || BOOT_WINDOW_CYC > 64'hFFFF_FFFF || LOAD_QUIET_CYC < 2 ||
      LOAD_QUIET_CYC > 64'hFFFF_FFFF || PULSE_TIMEOUT_CYC < 2 ||
      PULSE_TIMEOUT_CYC > 64'h3_FFFF_FFFF)
  begin : g_chk
    $error("timing parameter out of range");
  end

  typedef enum logic [2:0] {
    ST_BOOT_WAIT, ST_BOOT_REC, ST_RUN, ST_SIM_PARSE, ST_CALC_PER, ST_CALC_DIG, ST_SEND
  } state_t;

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
    if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
    if (c >= 8'h61 && c <= 8'h66) return {1'b1, 4'(c - 8'h57)};
    return 5'h00;
  endfunction

  function automatic logic [7:0] digc(input logic [3:0] d);
    return CH_ZERO + {4'h0, d};
  endfunction

  state_t state_q, state_d, ret_q, ret_d;
  logic ack_q, ack_d, tx_valid_q, tx_valid_d, cpu_rst_q, cpu_rst_d, loaded_q, loaded_d;
  logic nib_hi_q, nib_hi_d, skip_q, skip_d, div_start_q, div_start_d;
  logic [6:0] col_q, col_d;
  logic [7:0] tx_data_q, tx_data_d, len_q, len_d, type_q, type_d, sum_q, sum_d;
  logic [3:0] hi_nib_q, hi_nib_d, calc_k_q, calc_k_d;
  logic [8:0] idx_q, idx_d;
  logic [15:0] addr_q, addr_d;
  logic [31:0] timer_q, timer_d;
  logic [1:0] fld_q, fld_d;
  logic [2:0] calc_f_q, calc_f_d;
  logic [31:0] sim_q [3];
  logic [31:0] sim_d [3];
  logic [3:0] dig_q [6][10];
  logic [3:0] dig_d [6][10];
  logic [47:0] per_q, per_d, div_num_q, div_num_d, div_den_q, div_den_d;
  prog_wr_t prog_q, prog_d;
  logic div_done;
  logic [47:0] div_quo, div_rem, temp_scaled, temp_abs, mag_abs, fval;
  logic temp_neg, mag_neg, tx_load;
  logic [6:0] msg_len;
  logic [7:0] ch;

  udiv #(.W(48)) u_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(div_start_q),
    .num_i(div_num_q),
    .den_i(div_den_q),
    .done_o(div_done),
    .quo_o(div_quo),
    .rem_o(div_rem)
  );

  //////////////////////////////////////////////////////////////////////////////
  // derived readings
  assign temp_scaled = (48'(sim_q[2]) * TEMP_MUL + TEMP_ROUND) >> TEMP_SHIFT;
  assign temp_neg = temp_scaled < TEMP_OFS_TENTHS;
  assign temp_abs = temp_neg ? TEMP_OFS_TENTHS - temp_scaled : temp_scaled - TEMP_OFS_TENTHS;
  assign mag_neg = sky_mag_i[15];
  assign mag_abs = mag_neg ? 48'(-$signed(sky_mag_i)) : 48'(sky_mag_i);
  assign msg_len = ack_q ? ACK_LEN : REPLY_LEN;
  assign tx_load = state_q == ST_SEND && (!tx_valid_q || tx_ready_i) && col_q != msg_len;

  // value of the next field to be converted to digits, selected by calc_f_q + 1
  always_comb
  begin
    unique case (3'(calc_f_q + 3'd1))
      3'd0: fval = 48'(sim_q[0]);
      3'd1: fval = 48'(sim_q[1]);
      3'd2: fval = 48'(sim_q[2]);
      3'd3: fval = (mag_abs > MAG_MAX) ? MAG_MAX : mag_abs;
      3'd4: fval = per_q;
      default: fval = temp_abs;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // reply character at the current column
  always_comb
  begin
    ch = CH_SPACE;
    if (ack_q)
    begin
      unique case (col_q)
        7'd0: ch = CH_OU;
        7'd1: ch = CH_K;
        7'd2: ch = CH_CR;
        default: ch = CH_LF;
      endcase
    end
    else
    begin
      case (col_q) inside
        7'd0: ch = CH_S;
        7'd1, COL_COUNT + 7'd11, COL_FREQ + 7'd11, COL_RAW + 7'd11, COL_RSEP + 7'd1,
        COL_MAG + 7'd7, COL_HZ + 7'd12, COL_CNT2 + 7'd11, COL_PER + 7'd12: ch = CH_COMMA;
        [COL_COUNT:COL_COUNT + 7'd9]: ch = digc(dig_q[0][4'(COL_COUNT + 7'd9 - col_q)]);
        COL_COUNT + 7'd10: ch = CH_C;
        [COL_FREQ:COL_FREQ + 7'd9]: ch = digc(dig_q[1][4'(COL_FREQ + 7'd9 - col_q)]);
        COL_FREQ + 7'd10: ch = CH_F;
        [COL_RAW:COL_RAW + 7'd9]: ch = digc(dig_q[2][4'(COL_RAW + 7'd9 - col_q)]);
        COL_RAW + 7'd10: ch = CH_T;
        COL_RSEP: ch = CH_R;
        COL_MAG: ch = mag_neg ? CH_MINUS : CH_SPACE;
        [COL_MAG + 7'd1:COL_MAG + 7'd2]: ch = digc(dig_q[3][4'(COL_MAG + 7'd4 - col_q)]);
        COL_MAG + 7'd3, COL_PER + 7'd7, COL_TEMP + 7'd4: ch = CH_DOT;
        [COL_MAG + 7'd4:COL_MAG + 7'd5]: ch = digc(dig_q[3][4'(COL_MAG + 7'd5 - col_q)]);
        COL_MAG + 7'd6: ch = CH_M;
        [COL_HZ:COL_HZ + 7'd9]: ch = digc(dig_q[1][4'(COL_HZ + 7'd9 - col_q)]);
        COL_HZ + 7'd10: ch = CH_HU;
        COL_HZ + 7'd11: ch = CH_Z;
        [COL_CNT2:COL_CNT2 + 7'd9]: ch = digc(dig_q[0][4'(COL_CNT2 + 7'd9 - col_q)]);
        COL_CNT2 + 7'd10: ch = CH_C;
        [COL_PER:COL_PER + 7'd6]: ch = digc(dig_q[4][4'(COL_PER + 7'd9 - col_q)]);
        [COL_PER + 7'd8:COL_PER + 7'd10]: ch = digc(dig_q[4][4'(COL_PER + 7'd10 - col_q)]);
        COL_PER + 7'd11: ch = CH_SEC;
        COL_TEMP: ch = temp_neg ? CH_MINUS : CH_SPACE;
        [COL_TEMP + 7'd1:COL_TEMP + 7'd3]: ch = digc(dig_q[5][4'(COL_TEMP + 7'd4 - col_q)]);
        COL_TEMP + 7'd5: ch = digc(dig_q[5][0]);
        COL_TEMP + 7'd6: ch = CH_CU;
        COL_CRLF: ch = CH_CR;
        COL_CRLF + 7'd1: ch = CH_LF;
        default: ch = CH_SPACE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command, loader and reply sequencing
  always_comb
  begin
    logic [4:0] hv;
    logic [7:0] b;
    hv = hex_val(rx_data_i);
    b = {hi_nib_q, hv[3:0]};
    state_d = state_q;
    ret_d = ret_q;
    ack_d = ack_q;
    col_d = col_q;
    tx_valid_d = tx_valid_q;
    tx_data_d = tx_data_q;
    cpu_rst_d = 1'b0;
    loaded_d = loaded_q;
    nib_hi_d = nib_hi_q;
    hi_nib_d = hi_nib_q;
    idx_d = idx_q;
    len_d = len_q;
    addr_d = addr_q;
    type_d = type_q;
    sum_d = sum_q;
    timer_d = timer_q;
    fld_d = fld_q;
    skip_d = skip_q;
    sim_d = sim_q;
    dig_d = dig_q;
    per_d = per_q;
    calc_f_d = calc_f_q;
    calc_k_d = calc_k_q;
    div_start_d = 1'b0;
    div_num_d = div_num_q;
    div_den_d = div_den_q;
    prog_d = prog_q;
    prog_d.we = 1'b0;
    unique case (state_q)
      ST_BOOT_WAIT, ST_BOOT_REC:
      begin
        timer_d = timer_q + 32'd1;
        if (rx_valid_i && rx_data_i == CH_COLON)
        begin
          state_d = ST_BOOT_REC;
          timer_d = '0;
          idx_d = '0;
          nib_hi_d = 1'b1;
          sum_d = '0;
        end
        else if (timer_q == (loaded_q ? 32'(LOAD_QUIET_CYC - 1) : 32'(BOOT_WINDOW_CYC - 1)))
        begin
          timer_d = '0;
          loaded_d = 1'b0;
          cpu_rst_d = loaded_q;
          state_d = loaded_q ? ST_BOOT_WAIT : ST_RUN;
        end
        else if (rx_valid_i && state_q == ST_BOOT_REC)
        begin
          timer_d = '0;
          if (!hv[4])
            state_d = ST_BOOT_WAIT;
          else if (nib_hi_q)
          begin
            hi_nib_d = hv[3:0];
            nib_hi_d = 1'b0;
          end
          else
          begin
            nib_hi_d = 1'b1;
            sum_d = sum_q + b;
            idx_d = idx_q + 9'd1;
            if (idx_q >= 9'd4 && idx_q == 9'(len_q) + 9'd4)
            begin
              state_d = ST_BOOT_WAIT;
              if (8'(sum_q + b) == 8'h00)
              begin
                loaded_d = 1'b1;
                state_d = ST_SEND;
                ack_d = 1'b1;
                col_d = '0;
                ret_d = ST_BOOT_WAIT;
              end
            end
            else
            begin
              unique case (idx_q)
                9'd0: len_d = b;
                9'd1: addr_d[15:8] = b;
                9'd2: addr_d[7:0] = b;
                9'd3: type_d = b;
                default:
                begin
                  prog_d.we = type_q == 8'h00;
                  prog_d.addr = addr_q + 16'(idx_q - 9'd4);
                  prog_d.data = b;
                end
              endcase
            end
          end
        end
      end
      ST_RUN:
      begin
        if (rx_valid_i && rx_data_i == CH_RESET)
        begin
          cpu_rst_d = 1'b1;
          state_d = ST_BOOT_WAIT;
          timer_d = '0;
          loaded_d = 1'b0;
        end
        else if (rx_valid_i && rx_data_i == CH_S)
        begin
          state_d = ST_SIM_PARSE;
          fld_d = '0;
          skip_d = 1'b1;
          for (int i = 0; i < 3; i++) sim_d[i] = '0;
        end
      end
      ST_SIM_PARSE:
      begin
        if (rx_valid_i)
        begin
          skip_d = 1'b0;
          if (rx_data_i == CH_X)
          begin
            state_d = ST_CALC_PER;
            div_start_d = 1'b1;
            div_num_d = 48'(sim_q[0]) * MS_PER_S + (COUNT_RATE_HZ >> 1);
            div_den_d = COUNT_RATE_HZ;
          end
          else if (rx_data_i >= CH_ZERO && rx_data_i <= 8'h39)
            sim_d[fld_q] = 32'(sim_q[fld_q] * 32'd10) + 32'(rx_data_i - CH_ZERO);
          else if (!skip_q && fld_q != 2'd2)
            fld_d = fld_q + 2'd1;
        end
      end
      ST_CALC_PER:
      begin
        if (div_done)
        begin
          per_d = div_quo;
          state_d = ST_CALC_DIG;
          calc_f_d = '0;
          calc_k_d = '0;
          div_start_d = 1'b1;
          div_num_d = 48'(sim_q[0]);
          div_den_d = DEC_BASE;
        end
      end
      ST_CALC_DIG:
      begin
        if (div_done)
        begin
          dig_d[calc_f_q][calc_k_q] = div_rem[3:0];
          div_start_d = 1'b1;
          div_den_d = DEC_BASE;
          div_num_d = div_quo;
          calc_k_d = calc_k_q + 4'd1;
          if (calc_k_q == 4'd9)
          begin
            calc_k_d = '0;
            calc_f_d = calc_f_q + 3'd1;
            div_num_d = fval;
            if (calc_f_q == 3'd5)
            begin
              div_start_d = 1'b0;
              state_d = ST_SEND;
              ack_d = 1'b0;
              col_d = '0;
              ret_d = ST_RUN;
            end
          end
        end
      end
      ST_SEND:
      begin
        if (!tx_valid_q || tx_ready_i)
        begin
          if (col_q == msg_len)
          begin
            tx_valid_d = 1'b0;
            state_d = ret_q;
            timer_d = '0;
          end
          else
          begin
            tx_valid_d = 1'b1;
            tx_data_d = ch;
            col_d = col_q + 7'd1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_BOOT_WAIT;
      ret_q <= ST_RUN;
      ack_q <= 1'b0;
      col_q <= '0;
      tx_valid_q <= 1'b0;
      tx_data_q <= '0;
      cpu_rst_q <= 1'b0;
      loaded_q <= 1'b0;
      nib_hi_q <= 1'b1;
      hi_nib_q <= '0;
      idx_q <= '0;
      len_q <= '0;
      addr_q <= '0;
      type_q <= '0;
      sum_q <= '0;
      timer_q <= '0;
      fld_q <= '0;
      skip_q <= 1'b0;
      sim_q <= '{default: '0};
      dig_q <= '{default: '{default: '0}};
      per_q <= '0;
      calc_f_q <= '0;
      calc_k_q <= '0;
      div_start_q <= 1'b0;
      div_num_q <= '0;
      div_den_q <= '0;
      prog_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      ret_q <= ret_d;
      ack_q <= ack_d;
      col_q <= col_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
      cpu_rst_q <= cpu_rst_d;
      loaded_q <= loaded_d;
      nib_hi_q <= nib_hi_d;
      hi_nib_q <= hi_nib_d;
      idx_q <= idx_d;
      len_q <= len_d;
      addr_q <= addr_d;
      type_q <= type_d;
      sum_q <= sum_d;
      timer_q <= timer_d;
      fld_q <= fld_d;
      skip_q <= skip_d;
      sim_q <= sim_d;
      dig_q <= dig_d;
      per_q <= per_d;
      calc_f_q <= calc_f_d;
      calc_k_q <= calc_k_d;
      div_start_q <= div_start_d;
      div_num_q <= div_num_d;
      div_den_q <= div_den_d;
      prog_q <= prog_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sensor pulse period with timeout
  logic [2:0] sync_q, sync_d;
  logic [33:0] pcnt_q, pcnt_d, period_q, period_d;
  logic pval_q, pval_d, pto_q, pto_d;

  always_comb
  begin
    sync_d = {sync_q[1:0], sensor_pulse_i};
    pcnt_d = pcnt_q + 34'd1;
    period_d = period_q;
    pval_d = 1'b0;
    pto_d = 1'b0;
    if (sync_q[1] && !sync_q[2])
    begin
      period_d = pcnt_q + 34'd1;
      pval_d = 1'b1;
      pcnt_d = '0;
    end
    else if (pcnt_q == 34'(PULSE_TIMEOUT_CYC - 1))
    begin
      pto_d = 1'b1;
      pcnt_d = '0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_q <= '0;
      pcnt_q <= '0;
      period_q <= '0;
      pval_q <= 1'b0;
      pto_q <= 1'b0;
    end
    else
    begin
      sync_q <= sync_d;
      pcnt_q <= pcnt_d;
      period_q <= period_d;
      pval_q <= pval_d;
      pto_q <= pto_d;
    end
  end

  assign tx_valid_o = tx_valid_q;
  assign tx_data_o = tx_data_q;
  assign cpu_reset_o = cpu_rst_q;
  assign prog_wr_o = prog_q;
  assign period_cycles_o = period_q;
  assign period_valid_o = pval_q;
  assign pulse_timeout_o = pto_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  AST_OPEN_S: assert property (tx_load && !ack_q && col_q == 7'd0 |=> tx_data_o == CH_S)
    else $error("reply does not open with S");
  AST_FREQ_F: assert property (tx_load && !ack_q && col_q == 7'd24 |=> tx_data_o == CH_F)
    else $error("frequency suffix wrong");
  AST_RAW_T: assert property (tx_load && !ack_q && col_q == 7'd36 |=> tx_data_o == CH_T)
    else $error("raw temperature suffix wrong");
  AST_READ_R: assert property (tx_load && !ack_q && col_q == 7'd38 |=> tx_data_o == CH_R)
    else $error("reading marker wrong");
  AST_PERIOD_S: assert property (tx_load && !ack_q && col_q == 7'd84 |=> tx_data_o == CH_SEC)
    else $error("period suffix wrong");
  AST_END_CR: assert property (tx_load && !ack_q && col_q == 7'd93 |=> tx_data_o == CH_CR)
    else $error("reply not ended by CR");
  AST_ACK_OK: assert property (tx_load && ack_q && col_q == 7'd0 |=> tx_data_o == CH_OU)
    else $error("acknowledge not Ok");
  AST_RESET_BYTE: assert property (state_q == ST_RUN && rx_valid_i
    && rx_data_i == CH_RESET |=> cpu_reset_o && state_q == ST_BOOT_WAIT ##1 !cpu_reset_o)
    else $error("reset byte not obeyed");
  AST_COLON: assert property ((state_q == ST_BOOT_WAIT || state_q == ST_BOOT_REC)
    && rx_valid_i && rx_data_i == CH_COLON |=> state_q == ST_BOOT_REC && idx_q == '0)
    else $error("colon did not start record");
  AST_IGNORE: assert property (state_q == ST_BOOT_WAIT && rx_valid_i |=> !prog_wr_o.we)
    else $error("stray byte written");
  AST_PULSE_TO: assert property (pulse_timeout_o
    |-> $past(pcnt_q) == 34'(PULSE_TIMEOUT_CYC - 1) && pcnt_q == '0)
    else $error("pulse timeout at wrong count");
endmodule
`default_nettype wire

// >>> verification/host_model.sv
// host side of the byte link: sends request bytes, collects reply bytes
// assumes the design byte ports run on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk_sys_i,
  // link
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic tx_ready_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic slow_i
);
  logic [7:0] got[$];
  logic [3:0] cnt_q = 4'h0;
  initial rx_valid_o = 1'b0;
  initial rx_data_o = 8'h00;
  assign tx_ready_o = !slow_i || cnt_q[1];
  always @(posedge clk_sys_i)
  begin
    cnt_q <= cnt_q + 4'h1;
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
  end
  task automatic send(input string s);
    for (int k = 0; k < s.len(); k++)
    begin
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= s[k];
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~s[k];
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// bench for the simulation reply and boot loader block
// assumes host_model drives the byte link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sim_boot_pkg::*;
  typedef struct packed {logic [31:0] c; logic [31:0] f; logic [31:0] r; logic [15:0] m;} row_t;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic rx_valid, tx_ready, tx_valid, cpu_reset, per_valid, pto;
  logic sensor = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic [15:0] sky_mag = 16'h0000;
  logic [33:0] per, last_per;
  prog_wr_t wr, last_wr;
  int n_errors = 0, total_checks = 0, cycles = 0, n_rst = 0, n_wr = 0, n_to = 0, base;
  string ctl = " ";
  row_t rows[3] = '{'{32'h16F30, 32'h0, 32'hF5, 16'h70C},
    '{32'h0, 32'h168, 32'h64, 16'hFF85}, '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h3FF, 16'h270F}};
  sim_reply_and_boot_loader #(.BOOT_WINDOW_CYC(200), .LOAD_QUIET_CYC(200),
    .PULSE_TIMEOUT_CYC(100)) sim_reply_and_boot_loader_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .sky_mag_i(sky_mag), .cpu_reset_o(cpu_reset), .prog_wr_o(wr),
    .sensor_pulse_i(sensor), .period_cycles_o(per), .period_valid_o(per_valid),
    .pulse_timeout_o(pto));
  host_model host_model_i (.clk_sys_i(clk_sys_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .tx_ready_o(tx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .slow_i(slow));
  initial forever #10 clk_sys_i = ~clk_sys_i;
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cpu_reset) n_rst <= n_rst + 1;
    if (wr.we) n_wr <= n_wr + 1;
    if (wr.we) last_wr <= wr;
    if (per_valid) last_per <= per;
    if (pto) n_to <= n_to + 1;
    if (cycles == 40000)
    begin
      n_errors += 1;
      give_verdict();
    end
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic cmp(input string s);
    for (int k = 0; k < 8000 && host_model_i.got.size() < s.len(); k++) tick(1);
    tick(8);
    check(34'(host_model_i.got.size()), 34'(s.len()));
    for (int k = 0; k < s.len() && k < host_model_i.got.size(); k++)
      check(34'(host_model_i.got[k]), 34'(s[k]));
    host_model_i.got.delete();
  endtask
  function automatic string reply(input row_t w);
    longint p, t, m, am, at;
    string s;
    p = (longint'(w.c) * 1000 + 230400) / 460800;
    t = ((longint'(w.r) * 825 + 128) >>> 8) - 500;
    m = longint'($signed(w.m));
    am = m < 0 ? -m : m;
    at = t < 0 ? -t : t;
    s = $sformatf("S,%010dc,%010df,%010dt,r,%s%02d.%02dm,", w.c, w.f, w.r, m < 0 ? "-" : " ",
      am / 100, am % 100);
    return {s, $sformatf("%010dHz,%010dc,%07d.%03ds,%s%03d.%01dC\r\n", w.f, w.c, p / 1000,
      p % 1000, t < 0 ? "-" : " ", at / 10, at % 10)};
  endfunction
  initial
  begin
    tick(16);
    check(34'({cpu_reset, tx_valid, wr.we}), 34'h0);
    rst_i <= 1'b0;
    tick(260);
    check(34'(n_rst), 34'h0);
    for (int i = 0; i < 3; i++)
    begin
      sky_mag <= rows[i].m;
      slow <= (i == 2);
      host_model_i.send($sformatf("S,%0d;%0d/%0dx", rows[i].c, rows[i].f, rows[i].r));
      cmp(reply(rows[i]));
      $display("test reply row %0d done", i);
    end
    slow <= 1'b0;
    ctl[0] = CH_RESET;
    host_model_i.send(ctl);
    tick(4);
    check(34'(n_rst), 34'h1);
    host_model_i.send("zz:01001000AB45");
    tick(60);
    cmp("");
    host_model_i.send(":01001000AB44");
    cmp("Ok\r\n");
    check(34'(n_wr), 34'h2);
    check(34'(last_wr), 34'({1'b1, 16'h0010, 8'hAB}));
    tick(260);
    check(34'(n_rst), 34'h2);
    tick(260);
    check(34'(n_rst), 34'h2);
    $display("test loader done");
    rst_i <= 1'b1;
    tick(3);
    check(34'({cpu_reset, tx_valid, wr.we}), 34'h0);
    rst_i <= 1'b0;
    host_model_i.send(":00000001FF");
    cmp("Ok\r\n");
    check(34'(n_wr), 34'h2);
    $display("test mid-run reset done");
    sensor <= 1'b1;
    tick(10);
    sensor <= 1'b0;
    tick(30);
    base = n_to;
    sensor <= 1'b1;
    tick(8);
    check(last_per, 34'h28);
    tick(142);
    check(34'(n_to - base), 34'h1);
    $display("test sensor done");
    give_verdict();
  end
endmodule
`default_nettype wire
